// ### design/oaru_pkg.sv
package oaru_pkg;

   typedef enum logic [2:0] {
      AM_DIRECT,
      AM_INDIRECT,
      AM_SHORT_IMM,
      AM_LONG_IMM,
      AM_REGISTER
   } addr_mode_t;

   typedef enum logic [2:0] {
      IND_NOMOD,
      IND_INC,
      IND_DEC,
      IND_ADD0,
      IND_SUB0,
      IND_BR_INC,
      IND_BR_DEC
   } ind_mode_t;

   typedef enum logic [1:0] {
      SRC_MEM,
      SRC_IMM,
      SRC_REG
   } oper_src_t;

endpackage : oaru_pkg

// ### design/oaru_regs.svh
// Contract
// - seven indirect modes: inc, dec, add index, subtract index, none, bit-reversed inc/dec
// - current aux register addresses the operand first, then register and pointer update
// - short immediate operand comes from a field of the single instruction word
// - long immediate operand is the whole second instruction word
// - register addressing takes a 16-bit CPU register value, no address or immediate
// - a repeated instruction issues once per cycle
// - repeat loads counter from addressed data word, or 8-bit short immediate
// - counter value N gives at most N + 1 executions of the next instruction
// - reset clears the repeat counter
// - all interrupts held off from repeat decode until the loop completes
// - aux register selector values 0 to 7 name the eight aux registers
// - direct address is 9-bit page pointer above 7 low instruction bits
// - aux select pointer holds 0 to 7 and picks the current aux register
`ifndef OARU_REGS_SVH
`define OARU_REGS_SVH

`define OA_WORD_W    16
`define OA_NUM_AUX   8
`define OA_ASEL_W    3
`define OA_PAGE_W    9
`define OA_DIR_W     7
`define OA_SIMM_W    8
`define OA_APB_AW    8
`define OA_APB_DW    32

// instruction word fields
`define OA_IND_MSB   6
`define OA_IND_LSB   4
`define OA_LDSEL_BIT 3
`define OA_SEL_MSB   2
`define OA_SEL_LSB   0

// register offsets (byte addresses)
`define OA_PAGE_OFS  8'h00
`define OA_ASEL_OFS  8'h04
`define OA_STAT_OFS  8'h08
`define OA_CNT_OFS   8'h0C
`define OA_AR_BASE   8'h20
`define OA_AR_MASK   8'hE3
`define OA_AR_IDX_LSB 2

// status bits
`define OA_STAT_ARMED 0
`define OA_STAT_LOOP  1
`define OA_STAT_HOLD  2

`define OA_ONE16     16'h0001

`endif

// ### design/operand_addressing_repeat_unit.sv
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "oaru_regs.svh"

module operand_addressing_repeat_unit (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      reset,
   // apb slave
   input  wire logic [`OA_APB_AW-1:0]     paddr,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [`OA_APB_DW-1:0]     pwdata,
   output logic      [`OA_APB_DW-1:0]     prdata,
   output logic                           pready,
   output logic                           pslverr,
   // decoded instruction
   input  wire logic                      instr_valid,
   output logic                           instr_ready,
   input  wire logic [`OA_WORD_W-1:0]     instr_word,
   input  wire logic [`OA_WORD_W-1:0]     instr_ext,
   input  wire oaru_pkg::addr_mode_t      instr_mode,
   input  wire logic                      instr_is_repeat,
   input  wire logic [`OA_WORD_W-1:0]     reg_operand,
   input  wire logic [`OA_WORD_W-1:0]     mem_rdata,
   // operand issue
   output logic                           oper_valid,
   output logic      [`OA_WORD_W-1:0]     oper_addr,
   output logic      [`OA_WORD_W-1:0]     oper_value,
   output oaru_pkg::oper_src_t            oper_src,
   output logic                           int_holdoff
);
   import oaru_pkg::*;

   typedef struct packed {
      logic [`OA_NUM_AUX-1:0][`OA_WORD_W-1:0] ar;
      logic [`OA_ASEL_W-1:0]                  asel;
      logic [`OA_PAGE_W-1:0]                  page;
      logic [`OA_WORD_W-1:0]                  rcnt;
      logic                                   armed;
      logic                                   looping;
      logic [`OA_WORD_W-1:0]                  h_word;
      logic [`OA_WORD_W-1:0]                  h_ext;
      addr_mode_t                             h_mode;
      logic                                   oper_valid;
      logic [`OA_WORD_W-1:0]                  oper_addr;
      logic [`OA_WORD_W-1:0]                  oper_value;
      oper_src_t                              oper_src;
      logic [`OA_APB_DW-1:0]                  prdata;
   } state_t;

   state_t                  s_q;
   state_t                  s_d;

   logic                    acc;
   logic                    act;
   logic                    cur_repeat;
   logic [`OA_WORD_W-1:0]   cur_word;
   logic [`OA_WORD_W-1:0]   cur_ext;
   addr_mode_t              cur_mode;
   ind_mode_t               cur_ind;
   logic [`OA_WORD_W-1:0]   cur_ar;
   logic [`OA_WORD_W-1:0]   br_res;
   logic [`OA_WORD_W-1:0]   ar_next;
   logic [`OA_WORD_W-1:0]   op_addr;
   logic [`OA_WORD_W-1:0]   op_value;
   oper_src_t               op_src;
   logic                    apb_setup;
   logic                    apb_wr;
   logic                    ar_hit;
   logic [`OA_ASEL_W-1:0]   ar_idx;
   logic                    addr_hit;
   logic [`OA_APB_DW-1:0]   rd_val;

   // a loop owns the issue slot, so new instructions wait
   assign instr_ready = !s_q.looping;
   assign acc         = instr_valid && instr_ready;
   assign act         = acc || s_q.looping;
   assign cur_repeat  = acc && instr_is_repeat;
   assign cur_word    = s_q.looping ? s_q.h_word : instr_word;
   assign cur_ext     = s_q.looping ? s_q.h_ext : instr_ext;
   assign cur_mode    = s_q.looping ? s_q.h_mode : instr_mode;
   assign cur_ind     = ind_mode_t'(cur_word[`OA_IND_MSB:`OA_IND_LSB]);
   assign cur_ar      = s_q.ar[s_q.asel];

   rev_carry_add #(
      .W (`OA_WORD_W)
   ) u_rev (
      .a   (cur_ar),
      .b   (s_q.ar[0]),
      .sub (cur_ind == IND_BR_DEC),
      .y   (br_res)
   );

   // post-modification of the current aux register
   always_comb begin
      unique case (cur_ind)
         IND_NOMOD:  ar_next = cur_ar;
         IND_INC:    ar_next = cur_ar + `OA_ONE16;
         IND_DEC:    ar_next = cur_ar - `OA_ONE16;
         IND_ADD0:   ar_next = cur_ar + s_q.ar[0];
         IND_SUB0:   ar_next = cur_ar - s_q.ar[0];
         IND_BR_INC: ar_next = br_res;
         IND_BR_DEC: ar_next = br_res;
         default:    ar_next = cur_ar;
      endcase
   end

   // operand source selection
   always_comb begin
      op_addr  = '0;
      op_value = '0;
      op_src   = SRC_MEM;
      unique case (cur_mode)
         AM_DIRECT: begin
            op_addr = {s_q.page, cur_word[`OA_DIR_W-1:0]};
         end
         AM_INDIRECT: begin
            op_addr = cur_ar;
         end
         AM_SHORT_IMM: begin
            op_value = {{(`OA_WORD_W-`OA_SIMM_W){1'b0}}, cur_word[`OA_SIMM_W-1:0]};
            op_src   = SRC_IMM;
         end
         AM_LONG_IMM: begin
            op_value = cur_ext;
            op_src   = SRC_IMM;
         end
         AM_REGISTER: begin
            op_value = reg_operand;
            op_src   = SRC_REG;
         end
         default: begin
            op_addr = '0;
         end
      endcase
   end

   // apb decode; zero wait states, reads captured in the setup cycle
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite;
   assign ar_hit    = (paddr & `OA_AR_MASK) == `OA_AR_BASE;
   assign ar_idx    = paddr[`OA_AR_IDX_LSB+`OA_ASEL_W-1:`OA_AR_IDX_LSB];
   assign addr_hit  = ar_hit || paddr == `OA_PAGE_OFS || paddr == `OA_ASEL_OFS
                      || paddr == `OA_STAT_OFS || paddr == `OA_CNT_OFS;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !addr_hit;

   always_comb begin
      rd_val = '0;
      if (paddr == `OA_PAGE_OFS) begin
         rd_val[`OA_PAGE_W-1:0] = s_q.page;
      end else if (paddr == `OA_ASEL_OFS) begin
         rd_val[`OA_ASEL_W-1:0] = s_q.asel;
      end else if (paddr == `OA_STAT_OFS) begin
         rd_val[`OA_STAT_ARMED] = s_q.armed;
         rd_val[`OA_STAT_LOOP]  = s_q.looping;
         rd_val[`OA_STAT_HOLD]  = int_holdoff;
      end else if (paddr == `OA_CNT_OFS) begin
         rd_val[`OA_WORD_W-1:0] = s_q.rcnt;
      end else if (ar_hit) begin
         rd_val[`OA_WORD_W-1:0] = s_q.ar[ar_idx];
      end
   end

   // next state: software writes first, the instruction stream overrides them
   always_comb begin
      s_d            = s_q;
      s_d.oper_valid = 1'b0;
      if (apb_setup) begin
         s_d.prdata = rd_val;
      end
      if (apb_wr) begin
         if (paddr == `OA_PAGE_OFS) begin
            s_d.page = pwdata[`OA_PAGE_W-1:0];
         end else if (paddr == `OA_ASEL_OFS) begin
            s_d.asel = pwdata[`OA_ASEL_W-1:0];
         end else if (ar_hit) begin
            s_d.ar[ar_idx] = pwdata[`OA_WORD_W-1:0];
         end
      end
      if (act) begin
         if (cur_mode == AM_INDIRECT) begin
            // address already taken from cur_ar, modify afterwards
            s_d.ar[s_q.asel] = ar_next;
            if (cur_word[`OA_LDSEL_BIT]) begin
               s_d.asel = cur_word[`OA_SEL_MSB:`OA_SEL_LSB];
            end
         end
         if (cur_repeat) begin
            if (cur_mode == AM_SHORT_IMM) begin
               s_d.rcnt = {{(`OA_WORD_W-`OA_SIMM_W){1'b0}}, cur_word[`OA_SIMM_W-1:0]};
            end else begin
               s_d.rcnt = mem_rdata;
            end
            s_d.armed = 1'b1;
         end else begin
            s_d.oper_valid = 1'b1;
            s_d.oper_addr  = op_addr;
            s_d.oper_value = op_value;
            s_d.oper_src   = op_src;
            if (s_q.armed) begin
               s_d.h_word = cur_word;
               s_d.h_ext  = cur_ext;
               s_d.h_mode = cur_mode;
               if (s_q.rcnt == '0) begin
                  s_d.armed   = 1'b0;
                  s_d.looping = 1'b0;
               end else begin
                  s_d.rcnt    = s_q.rcnt - `OA_ONE16;
                  s_d.looping = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata      = s_q.prdata;
   assign oper_valid  = s_q.oper_valid;
   assign oper_addr   = s_q.oper_addr;
   assign oper_value  = s_q.oper_value;
   assign oper_src    = s_q.oper_src;
   // even the nonmaskable interrupt waits; holdoff ends with the last repeated execution or reset
   assign int_holdoff = s_q.armed || s_q.looping;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence loop_more_s;
      s_q.looping && s_q.rcnt != '0;
   endsequence

   sequence loop_last_s;
      s_q.looping && s_q.rcnt == '0;
   endsequence

   sequence loop_gone_s;
      s_q.oper_valid && !s_q.looping && !s_q.armed;
   endsequence

   // own disable: the default one would mask exactly the cycles checked here
   rcnt_reset_a: assert property (@(posedge clk) disable iff (1'b0) reset |=> s_q.rcnt == '0)
      else $error("repeat counter not cleared by reset");

   direct_addr_a: assert property (acc && !cur_repeat && cur_mode == AM_DIRECT
      |=> oper_valid && oper_addr == {$past(s_q.page), $past(instr_word[`OA_DIR_W-1:0])})
      else $error("direct address not page pointer over low bits");

   indir_addr_a: assert property (act && !cur_repeat && cur_mode == AM_INDIRECT
      |=> oper_valid && oper_addr == $past(cur_ar))
      else $error("indirect address not the pre-modification aux register");

   post_inc_a: assert property (act && cur_mode == AM_INDIRECT && cur_ind == IND_INC
      |=> s_q.ar[$past(s_q.asel)] == $past(cur_ar) + `OA_ONE16)
      else $error("post-increment did not add one");

   post_sub_a: assert property (act && cur_mode == AM_INDIRECT && cur_ind == IND_SUB0
      |=> s_q.ar[$past(s_q.asel)] == $past(cur_ar) - $past(s_q.ar[0]))
      else $error("post-subtract of index register wrong");

   short_imm_a: assert property (acc && !cur_repeat && instr_mode == AM_SHORT_IMM
      |=> oper_src == SRC_IMM && oper_value[`OA_SIMM_W-1:0] == $past(instr_word[`OA_SIMM_W-1:0]))
      else $error("short immediate not taken from instruction field");

   long_imm_a: assert property (acc && !cur_repeat && instr_mode == AM_LONG_IMM
      |=> oper_src == SRC_IMM && oper_value == $past(instr_ext))
      else $error("long immediate not the second word");

   reg_src_a: assert property (acc && !cur_repeat && instr_mode == AM_REGISTER
      |=> oper_src == SRC_REG && oper_value == $past(reg_operand))
      else $error("register operand not passed through");

   rcnt_load_a: assert property (cur_repeat && instr_mode == AM_SHORT_IMM
      |=> s_q.armed && s_q.rcnt == {8'h00, $past(instr_word[`OA_SIMM_W-1:0])})
      else $error("repeat counter not loaded from short immediate");

   hold_start_a: assert property (cur_repeat |=> int_holdoff && !oper_valid)
      else $error("interrupts not held off after repeat decode");

   loop_step_a: assert property (loop_more_s
      |=> s_q.oper_valid && s_q.looping && s_q.rcnt == $past(s_q.rcnt) - `OA_ONE16)
      else $error("repeat step did not issue and decrement");

   loop_end_a: assert property (loop_last_s |=> loop_gone_s)
      else $error("repeat loop did not end after the zero execution");

   per_cycle_a: assert property (s_q.looping |-> !instr_ready ##1 oper_valid)
      else $error("repeated instruction missed a cycle");

   asel_load_a: assert property (act && cur_mode == AM_INDIRECT && cur_word[`OA_LDSEL_BIT]
      |=> s_q.asel == $past(cur_word[`OA_SEL_MSB:`OA_SEL_LSB]))
      else $error("aux select pointer not loaded from selector");

endmodule : operand_addressing_repeat_unit

`default_nettype wire

// ### design/rev_carry_add.sv
`timescale 1ns/1ps
`default_nettype none

// carry travels msb toward lsb: reverse, add, reverse back
module rev_carry_add #(
   parameter int W = 16
) (
   // operands
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         sub,
   // result
   output logic      [W-1:0] y
);

   logic [W-1:0] ra;
   logic [W-1:0] rb;
   logic [W-1:0] rs;

   always_comb begin
      for (int i = 0; i < W; i++) begin
         ra[i] = a[W-1-i];
         rb[i] = b[W-1-i];
      end
      rs = sub ? (ra - rb) : (ra + rb);
      for (int i = 0; i < W; i++) begin
         y[i] = rs[W-1-i];
      end
   end

endmodule : rev_carry_add

`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "oaru_regs.svh"

module tb;
   import oaru_pkg::*;
   logic        clk             = 1'b0;
   logic        reset           = 1'b1;
   logic [7:0]  paddr           = 8'h00;
   logic        psel            = 1'b0;
   logic        penable         = 1'b0;
   logic        pwrite          = 1'b0;
   logic [31:0] pwdata          = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        instr_valid     = 1'b0;
   logic        instr_ready;
   logic [15:0] instr_word      = 16'h0;
   logic [15:0] instr_ext       = 16'h0;
   addr_mode_t  instr_mode      = AM_DIRECT;
   logic        instr_is_repeat = 1'b0;
   logic [15:0] reg_operand     = 16'h0;
   logic [15:0] mem_rdata       = 16'h0;
   logic        oper_valid;
   logic [15:0] oper_addr;
   logic [15:0] oper_value;
   oper_src_t   oper_src;
   logic        int_holdoff;
   int          num_errors      = 0;
   int          check_count     = 0;
   int          cycles          = 0;
   logic [15:0] ar [8];
   logic [2:0]  asel            = 3'h0;
   logic [31:0] rd;
   logic        err;

   always #25 clk = ~clk;

   operand_addressing_repeat_unit i_operand_addressing_repeat_unit (
      .clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_word(instr_word),
      .instr_ext(instr_ext), .instr_mode(instr_mode), .instr_is_repeat(instr_is_repeat),
      .reg_operand(reg_operand), .mem_rdata(mem_rdata), .oper_valid(oper_valid),
      .oper_addr(oper_addr), .oper_value(oper_value), .oper_src(oper_src), .int_holdoff(int_holdoff)
   );

   task summarize;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; the request is held until pready is seen at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      paddr   <= a;
      pwrite  <= wr;
      pwdata  <= d;
      psel    <= 1'b1;
      penable <= 1'b0;
      @(posedge clk);
      penable <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk(err, experr);
   endtask : rdchk

   // offer one instruction and hold it until accepted
   task issue(input addr_mode_t m, input logic [15:0] w, input logic [15:0] x, input logic rep);
      instr_valid     <= 1'b1;
      instr_mode      <= m;
      instr_word      <= w;
      instr_ext       <= x;
      instr_is_repeat <= rep;
      for (int n = 0; n < 50; n++) begin
         @(negedge clk);
         if (instr_ready === 1'b1) break;
      end
      if (instr_ready !== 1'b1) num_errors++;
      @(posedge clk);
      instr_valid     <= 1'b0;
      instr_is_repeat <= 1'b0;
   endtask : issue

   task opchk(input logic [15:0] a, input logic [15:0] v, input oper_src_t s);
      @(negedge clk);
      chk(oper_valid, 1);
      chk(oper_addr, a);
      chk(oper_value, v);
      chk(oper_src, s);
      @(posedge clk);
   endtask : opchk

   function automatic logic [15:0] rev(input logic [15:0] v);
      for (int i = 0; i < 16; i++) rev[i] = v[15-i];
   endfunction : rev

   // expected register after one indirect access
   function automatic logic [15:0] modify(input logic [2:0] m, input logic [15:0] a, input logic [15:0] x);
      case (m)
         3'd1: modify = a + 16'h0001;
         3'd2: modify = a - 16'h0001;
         3'd3: modify = a + x;
         3'd4: modify = a - x;
         3'd5: modify = rev(rev(a) + rev(x));
         3'd6: modify = rev(rev(a) - rev(x));
         default: modify = a;
      endcase
   endfunction : modify

   task ind(input logic [2:0] m, input logic ldp, input logic [2:0] sel);
      issue(AM_INDIRECT, {9'h0, m, ldp, sel}, 16'h0, 1'b0);
      opchk(ar[asel], 16'h0, SRC_MEM);
      ar[asel] = modify(m, ar[asel], ar[0]);
      if (ldp) asel = sel;
   endtask : ind

   // repeat, then an auto-increment access that should run n+1 times back to back;
   // holdoff already drops in the cycle that shows the last execution
   task repeat_run(input addr_mode_t m, input logic [15:0] w, input logic [15:0] mem, input int n);
      int cnt;
      mem_rdata <= mem;
      issue(m, w, 16'h0, 1'b1);
      @(negedge clk);
      chk(int_holdoff, 1);
      chk(oper_valid, 0);
      @(posedge clk);
      issue(AM_INDIRECT, 16'h0010, 16'h0, 1'b0);
      cnt = 0;
      for (int k = 0; k < n + 4; k++) begin
         @(negedge clk);
         chk(oper_valid, 32'(k <= n));
         if (oper_valid === 1'b1) begin
            chk(instr_ready, 32'(cnt == n));
            chk(int_holdoff, 32'(cnt != n));
            chk(oper_addr, ar[asel]);
            ar[asel] = ar[asel] + 16'h0001;
            cnt++;
         end
      end
      chk(cnt, n + 1);
      chk(int_holdoff, 0);
      @(posedge clk);
      rdchk(`OA_CNT_OFS, 32'h0, 1'b0);
   endtask : repeat_run

   // bounded run; a hang counts as a mismatch
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      rdchk(`OA_CNT_OFS, 32'h0, 1'b0);
      rdchk(`OA_PAGE_OFS, 32'h0, 1'b0);
      rdchk(`OA_ASEL_OFS, 32'h0, 1'b0);
      rdchk(`OA_STAT_OFS, 32'h0, 1'b0);
      rdchk(8'h10, 32'h0, 1'b1);
      apb(1'b1, `OA_PAGE_OFS, 32'h0000_01A5);
      rdchk(`OA_PAGE_OFS, 32'h0000_01A5, 1'b0);
      issue(AM_DIRECT, 16'hFFD5, 16'h0, 1'b0);
      opchk({9'h1A5, 7'h55}, 16'h0, SRC_MEM);
      for (int i = 0; i < 8; i++) begin
         rdchk(8'(`OA_AR_BASE + 4 * i), 32'h0, 1'b0);
         ar[i] = 16'(16'h0010 + 16'h1000 * i);
         apb(1'b1, 8'(`OA_AR_BASE + 4 * i), {16'h0, ar[i]});
      end
      apb(1'b1, `OA_ASEL_OFS, 32'h1);
      asel = 3'h1;
      for (int m = 0; m < 8; m++) ind(3'(m), 1'b0, 3'h0);
      ind(3'd1, 1'b1, 3'd5);
      rdchk(`OA_ASEL_OFS, 32'h5, 1'b0);
      ind(3'd2, 1'b0, 3'd0);
      issue(AM_SHORT_IMM, 16'h3CA7, 16'h0, 1'b0);
      opchk(16'h0, 16'h00A7, SRC_IMM);
      issue(AM_LONG_IMM, 16'h1234, 16'hBEEF, 1'b0);
      opchk(16'h0, 16'hBEEF, SRC_IMM);
      reg_operand <= 16'h5A3C;
      issue(AM_REGISTER, 16'h0, 16'h0, 1'b0);
      opchk(16'h0, 16'h5A3C, SRC_REG);
      repeat_run(AM_SHORT_IMM, 16'h3302, 16'hFFFF, 2);
      repeat_run(AM_SHORT_IMM, 16'h0000, 16'h0007, 0);
      repeat_run(AM_DIRECT, 16'h0005, 16'h0003, 3);
      for (int i = 0; i < 8; i++) rdchk(8'(`OA_AR_BASE + 4 * i), {16'h0, ar[i]}, 1'b0);
      summarize();
   end
endmodule : tb

`default_nettype wire
